/* File: include/sdm_pkg.sv */
package sdm_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_MODE = 6'h0b;
   localparam logic [5:0] IDX_MCLR = 6'h0d;
   localparam logic [5:0] IDX_MASK = 6'h0f;
   localparam logic [5:0] IDX_STAT = 6'h10;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h12;
   localparam logic [5:0] IDX_BASE = 6'h13;
   localparam logic [5:0] IDX_CUR = 6'h14;
   // mode register fields
   localparam int MODE_SEL_LSB = 6;
   localparam int DIR_BIT = 5;
   localparam int RELOAD_BIT = 4;
   localparam int TYPE_LSB = 2;
   localparam int MASK_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE_WR_MASK = 8'hfc;
   localparam logic MASK_RESET = 1'b0;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   // interrupt event bits
   localparam int EV_REMOVED = 0;
   localparam int EV_TC = 1;
   localparam int EV_BLOCKED = 2;
   localparam int EV_W = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {SDM_DEMAND, SDM_SINGLE, SDM_BLOCK, SDM_MODE_RSVD} sdm_mode_t;
   typedef enum logic [1:0] {SDM_NONE, SDM_WRITE, SDM_READ, SDM_TYPE_RSVD} sdm_type_t;

   function automatic logic [5:0] sdm_index(input logic [7:0] addr);
      sdm_index = addr[7:2];
   endfunction : sdm_index
endpackage : sdm_pkg

/* File: design/sdm_axil_port.sv */
module sdm_axil_port
   import sdm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [5:0] wr_idx,
   output logic [7:0] wr_data,
   output logic wr_lane0,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [5:0] rd_idx,
   input wire logic [7:0] rd_data,
   input wire logic rd_ok
);
   typedef struct packed {
      logic aw_done;
      logic w_done;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } sdm_axil_st_t;

   sdm_axil_st_t s_q, s_d;

   // address and data may arrive in either order; the write fires once both are held
   assign s_axi_awready = !s_q.aw_done && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_done && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign wr_en = s_q.aw_done && s_q.w_done && !s_q.bvalid;
   assign wr_idx = sdm_index(s_q.awaddr);
   assign wr_data = s_q.wdata;
   assign wr_lane0 = s_q.lane0;
   assign rd_en = s_axi_arvalid && s_axi_arready;
   assign rd_idx = sdm_index(s_axi_araddr);
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rdata = {24'h000000, s_q.rdata};

   always_comb
   begin
      s_d = s_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_d.aw_done = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_d.w_done = 1'b1;
         s_d.wdata = s_axi_wdata[7:0];
         s_d.lane0 = s_axi_wstrb[0];
      end
      if (wr_en)
      begin
         s_d.aw_done = 1'b0;
         s_d.w_done = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      if (rd_en)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_data;
         s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : sdm_axil_port

/* File: design/sdm_addr_step.sv */
module sdm_addr_step
   import sdm_pkg::*;
#(
   parameter int AW = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic load,
   input wire logic [AW-1:0] load_value,
   input wire logic step,
   input wire logic step_down,
   input wire logic reload,
   output logic [AW-1:0] base_addr,
   output logic [AW-1:0] cur_addr
);
   typedef struct packed {
      logic [AW-1:0] base;
      logic [AW-1:0] cur;
   } sdm_step_st_t;

   sdm_step_st_t s_q, s_d;

   assign base_addr = s_q.base;
   assign cur_addr = s_q.cur;

   always_comb
   begin
      s_d = s_q;
      if (clear)
      begin
         s_d.base = AW'(ADDR_RESET);
         s_d.cur = AW'(ADDR_RESET);
      end
      else if (load)
      begin
         s_d.base = load_value;
         s_d.cur = load_value;
      end
      else if (reload)
         s_d.cur = s_q.base;
      else if (step)
         s_d.cur = step_down ? s_q.cur - AW'(1) : s_q.cur + AW'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : sdm_addr_step

/* File: design/sdm_mode_mask.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
module sdm_mode_mask
   import sdm_pkg::*;
#(
   parameter int AW = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic card_dma_request,
   input wire logic card_present,
   input wire logic transfer_ack,
   input wire logic terminal_count,
   output logic service_request,
   output logic [1:0] transfer_mode_select,
   output logic address_direction,
   output logic auto_reload_enable,
   output logic [1:0] transfer_direction_type,
   output logic [AW-1:0] current_address,
   output logic irq
);
   typedef struct packed {
      logic [7:0] mode;
      logic card_request_block;
      logic req_prev;
      logic present_prev;
      logic single_pend;
      logic block_active;
      logic tc_flag;
      logic [EV_W-1:0] irq_stat;
      logic [EV_W-1:0] irq_mask;
      logic [1:0] mode_out;
      logic dir_out;
      logic reload_out;
      logic [1:0] type_out;
      logic service;
   } sdm_st_t;

   sdm_st_t s_q, s_d;

   logic wr_en;
   logic [5:0] wr_idx;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic wr_ok;
   logic rd_en;
   logic [5:0] rd_idx;
   logic [7:0] rd_data;
   logic rd_ok;
   logic master_clear;
   logic base_load;
   logic [AW-1:0] base_addr;
   logic [AW-1:0] cur_addr;
   logic req_rise;
   logic removed;
   logic chan_ok;
   logic step;
   logic reload;
   sdm_mode_t mode_sel;
   sdm_type_t xfer_type;

   sdm_axil_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .wr_lane0(wr_lane0),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // register decode
   always_comb
   begin
      case (wr_idx)
         IDX_MODE, IDX_MCLR, IDX_MASK, IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_BASE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // any write, any data, any byte lane: only the strobe is used, nothing is stored
   assign master_clear = wr_en && (wr_idx == IDX_MCLR);
   assign base_load = wr_en && wr_lane0 && (wr_idx == IDX_BASE);

   always_comb
   begin
      rd_ok = 1'b1;
      rd_data = 8'h00;
      case (rd_idx)
         IDX_MODE: rd_data = s_q.mode & MODE_WR_MASK;
         IDX_MCLR: rd_data = 8'h00;
         IDX_MASK: rd_data = {7'h00, s_q.card_request_block};
         IDX_STAT: rd_data = {{4{card_dma_request}}, {4{s_q.tc_flag}}};
         IDX_IRQ_STAT: rd_data = {{(8-EV_W){1'b0}}, s_q.irq_stat};
         IDX_IRQ_MASK: rd_data = {{(8-EV_W){1'b0}}, s_q.irq_mask};
         IDX_BASE: rd_data = base_addr[7:0];
         IDX_CUR: rd_data = cur_addr[7:0];
         default: rd_ok = 1'b0;
      endcase
   end

   assign mode_sel = sdm_mode_t'(s_q.mode[MODE_SEL_LSB +: 2]);
   assign xfer_type = sdm_type_t'(s_q.mode[TYPE_LSB +: 2]);
   assign req_rise = card_dma_request && !s_q.req_prev;
   assign removed = s_q.present_prev && !card_present;
   // reserved mode or type selections never open the channel
   assign chan_ok = !s_q.card_request_block && (mode_sel != SDM_MODE_RSVD)
      && (xfer_type == SDM_WRITE || xfer_type == SDM_READ);
   assign step = transfer_ack && s_q.service;
   assign reload = terminal_count && s_q.service && s_q.mode[RELOAD_BIT];

   sdm_addr_step #(
      .AW(AW)
   ) u_step (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(master_clear),
      .load(base_load),
      .load_value(AW'(wr_data)),
      .step(step),
      .step_down(s_q.mode[DIR_BIT]),
      .reload(reload),
      .base_addr(base_addr),
      .cur_addr(cur_addr)
   );

   always_comb
   begin
      s_d = s_q;
      s_d.req_prev = card_dma_request;
      s_d.present_prev = card_present;

      if (wr_en && wr_lane0)
      begin
         case (wr_idx)
            IDX_MODE: s_d.mode = wr_data & MODE_WR_MASK;
            IDX_MASK: s_d.card_request_block = wr_data[MASK_BIT];
            IDX_IRQ_MASK: s_d.irq_mask = wr_data[EV_W-1:0];
            IDX_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~wr_data[EV_W-1:0];
            default: s_d.mode = s_d.mode;
         endcase
      end

      // terminal count flag clears on a status read
      if (rd_en && rd_idx == IDX_STAT)
         s_d.tc_flag = 1'b0;

      // request servicing per mode; edges seen while blocked are dropped, not deferred
      if (!chan_ok)
      begin
         s_d.single_pend = 1'b0;
         s_d.block_active = 1'b0;
      end
      else
      begin
         case (mode_sel)
            SDM_SINGLE:
            begin
               if (transfer_ack && s_q.single_pend)
                  s_d.single_pend = 1'b0;
               if (req_rise)
                  s_d.single_pend = 1'b1;
            end
            SDM_BLOCK:
            begin
               if (terminal_count && s_q.block_active)
                  s_d.block_active = 1'b0;
               else if (req_rise)
                  s_d.block_active = 1'b1;
            end
            default:
            begin
               s_d.single_pend = 1'b0;
               s_d.block_active = 1'b0;
            end
         endcase
      end

      case (mode_sel)
         SDM_DEMAND: s_d.service = chan_ok && card_dma_request;
         SDM_SINGLE: s_d.service = chan_ok && s_d.single_pend;
         SDM_BLOCK: s_d.service = chan_ok && s_d.block_active;
         default: s_d.service = 1'b0;
      endcase

      // master clear returns the controller to reset; interrupt registers stay for software
      if (master_clear)
      begin
         s_d.mode = MODE_RESET;
         s_d.card_request_block = MASK_RESET;
         s_d.single_pend = 1'b0;
         s_d.block_active = 1'b0;
         s_d.tc_flag = 1'b0;
         s_d.service = 1'b0;
      end

      if (terminal_count && s_q.service)
         s_d.tc_flag = 1'b1;

      // removal sets the mask even against a same-cycle clear or software write
      if (removed)
      begin
         s_d.card_request_block = 1'b1;
         s_d.service = 1'b0;
         s_d.single_pend = 1'b0;
         s_d.block_active = 1'b0;
      end

      s_d.mode_out = s_d.mode[MODE_SEL_LSB +: 2];
      s_d.dir_out = s_d.mode[DIR_BIT];
      s_d.reload_out = s_d.mode[RELOAD_BIT];
      s_d.type_out = s_d.mode[TYPE_LSB +: 2];

      // events set after the software clear so a same-cycle event wins
      if (removed)
         s_d.irq_stat[EV_REMOVED] = 1'b1;
      if (terminal_count && s_q.service)
         s_d.irq_stat[EV_TC] = 1'b1;
      if (req_rise && s_q.card_request_block)
         s_d.irq_stat[EV_BLOCKED] = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign service_request = s_q.service;
   assign transfer_mode_select = s_q.mode_out;
   assign address_direction = s_q.dir_out;
   assign auto_reload_enable = s_q.reload_out;
   assign transfer_direction_type = s_q.type_out;
   assign current_address = cur_addr;
   assign irq = |(s_q.irq_stat & s_q.irq_mask);
endmodule : sdm_mode_mask

/* File: bench/sdm_mode_mask_monitor.sv */
module sdm_mode_mask_monitor
   import sdm_pkg::*;
#(
   parameter int AW = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic card_dma_request,
   input wire logic card_present,
   input wire logic transfer_ack,
   input wire logic terminal_count,
   input wire logic service_request,
   input wire logic [1:0] transfer_mode_select,
   input wire logic address_direction,
   input wire logic auto_reload_enable,
   input wire logic [1:0] transfer_direction_type,
   input wire logic [AW-1:0] current_address
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic wr_hs;
   logic ar_hs;
   logic [5:0] fields;
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign fields = {transfer_mode_select, address_direction, auto_reload_enable, transfer_direction_type};
   sequence mode_wr_s;
      wr_hs && s_axi_awaddr == {IDX_MODE, 2'b00} && s_axi_wstrb[0];
   endsequence
   sequence rd_s(a);
      ar_hs && s_axi_araddr == a;
   endsequence
   mode_write_a:
      assert property (mode_wr_s |-> ##2 fields == $past(s_axi_wdata[7:2], 2)) else $error("mode fields wrong");
   mode_read_a:
      assert property (rd_s({IDX_MODE, 2'b00}) |=> s_axi_rvalid && s_axi_rdata[7:0] == {fields, 2'b00})
      else $error("mode readback wrong");
   mask_read_a:
      assert property (rd_s({IDX_MASK, 2'b00}) |=> s_axi_rvalid && s_axi_rdata[7:1] == 7'h00)
      else $error("mask high bits set");
   status_raw_a:
      assert property (ar_hs && s_axi_araddr == {IDX_STAT, 2'b00} && $stable(card_dma_request)
         |=> s_axi_rdata[7:4] == {4{$past(card_dma_request)}}) else $error("status hides request");
   removal_mask_a:
      assert property ($fell(card_present) |-> ##4 !service_request [*3]) else $error("service after removal");
   service_cause_a:
      assert property ($rose(service_request) |-> $past(card_dma_request)) else $error("service without request");
   master_clear_a:
      assert property (wr_hs && s_axi_awaddr == {IDX_MCLR, 2'b00} |-> ##2 fields == 6'h00 && current_address == '0)
      else $error("master clear missed");
   addr_step_a:
      assert property (transfer_ack && service_request && !terminal_count && !wr_hs |=> current_address ==
         AW'($past(address_direction) ? $past(current_address) - 1 : $past(current_address) + 1))
      else $error("address step wrong");
endmodule : sdm_mode_mask_monitor

bind sdm_mode_mask sdm_mode_mask_monitor #(.AW(AW)) u_mon (.*);

/* File: bench/sdm_card_model.sv */
module sdm_card_model (
   input wire logic aclk,
   output logic card_dma_request,
   output logic card_present
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      card_dma_request = 1'b0;
      card_present = 1'b1;
   end
   // a pulled card leaves the request pin floating, so it must never look steady
   always @(posedge aclk)
      if (!card_present)
         card_dma_request <= ~card_dma_request;
   task automatic req(input logic v);
      @(posedge aclk);
      card_dma_request <= v;
   endtask : req
   task automatic seat(input logic v);
      @(posedge aclk);
      card_present <= v;
   endtask : seat
endmodule : sdm_card_model

/* File: bench/tb.sv */
module tb import sdm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_MODE = {IDX_MODE, 2'b00}, A_MCLR = {IDX_MCLR, 2'b00}, A_MASK = {IDX_MASK, 2'b00};
   localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00}, A_IS = {IDX_IRQ_STAT, 2'b00}, A_IM = {IDX_IRQ_MASK, 2'b00};
   localparam logic [7:0] A_BASE = {IDX_BASE, 2'b00}, A_CUR = {IDX_CUR, 2'b00};
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, transfer_ack, terminal_count;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, service_request;
   logic address_direction, auto_reload_enable, irq, card_dma_request, card_present;
   logic [1:0] s_axi_bresp, s_axi_rresp, transfer_mode_select, transfer_direction_type;
   logic [31:0] s_axi_rdata;
   logic [15:0] current_address;
   int n_fail = 0, checked = 0, cyc = 0;
   always #5 aclk = ~aclk;
   sdm_mode_mask #(.AW(16)) DUT (.*);
   sdm_card_model card (.aclk(aclk), .card_dma_request(card_dma_request), .card_present(card_present));
   task automatic report_and_stop();
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
      input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(34'(s_axi_bresp), 34'(r));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, e});
   endtask : rd
   task automatic pulse(input logic ack);
      @(posedge aclk);
      transfer_ack <= ack;
      terminal_count <= !ack;
      @(posedge aclk);
      transfer_ack <= 1'b0;
      terminal_count <= 1'b0;
   endtask : pulse
   task automatic svc(input logic e);
      repeat (3) @(posedge aclk);
      chk(34'(service_request), 34'(e));
   endtask : svc
   task automatic pull_card();
      card.seat(1'b0);
      repeat (4) @(posedge aclk);
      card.seat(1'b1);
      card.req(1'b1);
   endtask : pull_card
   initial
   begin
      logic [7:0] v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {transfer_ack, terminal_count} = 2'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_MODE, 8'h00);
      rd(A_MASK, 8'h00);
      rd(A_MCLR, 8'h00);
      rd(8'h00, 8'h00, RESP_SLVERR);
      wr(A_STAT, 8'h00, 4'h1, RESP_SLVERR);
      for (int i = 0; i < 4; i++)
      begin
         v = {2'(i), i[0], ~i[0], 2'(3 - i), 2'b11};
         wr(A_MODE, v);
         rd(A_MODE, v & 8'hfc);
      end
      wr(A_MODE, 8'h04);
      card.req(1'b1);
      svc(1'b1);
      rd(A_STAT, 8'hf0);
      pulse(1'b1);
      rd(A_CUR, 8'h01);
      wr(A_MODE, 8'h24);
      pulse(1'b1);
      rd(A_CUR, 8'h00);
      wr(A_MODE, 8'h00);
      svc(1'b0);
      wr(A_MODE, 8'h08);
      svc(1'b1);
      wr(A_BASE, 8'h40);
      wr(A_MODE, 8'h14);
      pulse(1'b1);
      rd(A_CUR, 8'h41);
      pulse(1'b0);
      rd(A_CUR, 8'h40);
      wr(A_MODE, 8'h44);
      card.req(1'b0);
      card.req(1'b1);
      svc(1'b1);
      pulse(1'b1);
      svc(1'b0);
      wr(A_MODE, 8'h84);
      card.req(1'b0);
      card.req(1'b1);
      svc(1'b1);
      pulse(1'b1);
      svc(1'b1);
      pulse(1'b0);
      svc(1'b0);
      wr(A_MODE, 8'h04);
      wr(A_IM, 8'h01);
      pull_card();
      svc(1'b0);
      rd(A_MASK, 8'h01);
      rd(A_STAT, 8'hff);
      rd(A_STAT, 8'hf0);
      chk(34'(irq), 34'h1);
      wr(A_IM, 8'h00);
      @(posedge aclk);
      chk(34'(irq), 34'h0);
      wr(A_IS, 8'h07);
      wr(A_IM, 8'h01);
      @(posedge aclk);
      chk(34'(irq), 34'h0);
      wr(A_MASK, 8'h00);
      svc(1'b1);
      wr(A_MODE, 8'hfc);
      pull_card();
      wr(A_MCLR, 8'h00, 4'h0);
      rd(A_MODE, 8'h00);
      rd(A_MASK, 8'h00);
      rd(A_CUR, 8'h00);
      wr(A_MODE, 8'h04);
      svc(1'b1);
      wr(A_MODE, 8'h9c);
      wr(A_MCLR, 8'hff);
      rd(A_MODE, 8'h00);
      report_and_stop();
   end
endmodule : tb
